// ===== src/drms_pkg.sv
package drms_pkg;
	localparam int unsigned ADDR_W = 14;
	localparam int unsigned LOW_W = 13;
	localparam int unsigned IO_W = 11;
	localparam int unsigned WAIT_W = 3;
	localparam int unsigned MODE_W = 3;
	localparam int unsigned IRQ_W = 8;
	localparam int unsigned MST_W = 8;
	localparam int unsigned AXI_AW = 8;
	// Register byte offsets.
	localparam logic [7:0] OFF_SYSCTL = 8'h00;
	localparam logic [7:0] OFF_OVLAY = 8'h04;
	localparam logic [7:0] OFF_WAIT = 8'h08;
	localparam logic [7:0] OFF_CMSCFG = 8'h0c;
	localparam logic [7:0] OFF_MODE_STAT = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_IRQMASK = 8'h18;
	// Field positions.
	localparam int unsigned SYS_FLAG_OUT = 0;
	localparam int unsigned SYS_FLAG_DIR = 1;
	localparam int unsigned SYS_BYTE_DIS = 3;
	localparam int unsigned OVL_PM_LSB = 0;
	localparam int unsigned OVL_DM_LSB = 4;
	localparam int unsigned WT_D_LSB = 0;
	localparam int unsigned WT_IO_LSB = 4;
	localparam int unsigned WT_IO_STEP = 4;
	localparam int unsigned WT_P_LSB = 20;
	localparam int unsigned IO_REG_LSB = 9;
	localparam int unsigned MODE_A = 0;
	localparam int unsigned MODE_B = 1;
	localparam int unsigned MODE_C = 2;
	localparam int unsigned COMP_PROG = 0;
	localparam int unsigned COMP_DATA = 1;
	localparam int unsigned COMP_BYTE = 2;
	localparam int unsigned COMP_IO = 3;
	localparam int unsigned ST_MODE_LSB = 0;
	localparam int unsigned ST_BOOT = 3;
	localparam int unsigned ST_RUN = 4;
	localparam int unsigned ST_GRANT = 5;
	localparam int unsigned ST_REFUSED = 6;
	localparam int unsigned ST_FLAG = 7;
	// Values.
	localparam logic [1:0] OVL_INT = 2'h0;
	localparam logic [1:0] OVL_EXT1 = 2'h1;
	localparam logic [1:0] OVL_EXT2 = 2'h2;
	localparam logic [3:0] COMP_CFG_RESET = 4'hb;
	localparam logic [13:0] FETCH_ADDR = 14'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		SP_PM = 2'h0,
		SP_DM = 2'h1,
		SP_BM = 2'h2,
		SP_IO = 2'h3
	} drms_space_e;
	typedef enum logic [2:0] {
		BT_RESET = 3'h1,
		BT_BOOT = 3'h2,
		BT_RUN = 3'h4
	} drms_boot_e;
	typedef enum logic [2:0] {
		AC_IDLE = 3'h1,
		AC_STROBE = 3'h2,
		AC_GRANT = 3'h4
	} drms_acc_e;
	typedef struct packed {
		drms_space_e space;
		logic write;
		logic [13:0] addr;
	} drms_req_s;
	typedef struct packed {
		logic program_memory_select_n;
		logic data_memory_select_n;
		logic byte_memory_select_n;
		logic io_space_select_n;
		logic composite_select_n;
	} drms_sel_s;
endpackage

// ===== src/drms_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module drms_pin_sync #(
	parameter int unsigned W = 5,
	parameter int unsigned STRAP_W = 3
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Pins and results.
	input wire logic [W-1:0] pin,
	output logic [W-1:0] pin_sync,
	output logic [STRAP_W-1:0] strap_q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge aclk) begin
		meta_q <= pin;
		pin_sync <= meta_q;
	end

	// Straps follow the synchronised pins only while reset is low, then freeze.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strap_q <= pin_sync[STRAP_W-1:0];
		end
	end

	strap_hold_a: assert property (@(posedge aclk) aresetn |=> $stable(strap_q))
		else $error("strap changed outside reset");
endmodule
`default_nettype wire

// ===== src/drms_wait_count.sv
`timescale 1ns/1ps
`default_nettype none
module drms_wait_count #(
	parameter int unsigned W = 3
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Control.
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic zero
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= load_val;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - W'(1);
		end
	end

	assign zero = (cnt_q == '0);

	count_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!load && !zero |=> cnt_q == $past(cnt_q) - W'(1))
		else $error("wait counter did not step down");
endmodule
`default_nettype wire

// ===== src/drms_top.sv
`timescale 1ns/1ps
`default_nettype none
module drms_top #(
	parameter int unsigned PM_WORDS = 16384,
	parameter int unsigned DM_USER_WORDS = 16352
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave.
	input wire logic [drms_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [drms_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Mode straps and shared flag pin.
	input wire logic mode_a_pin,
	input wire logic mode_b_pin,
	input wire logic shared_flag_pin_i,
	output logic shared_flag_pin_o,
	output logic shared_flag_pin_oe,
	// Core side.
	input wire logic boot_done,
	output logic stack_clear_q,
	output logic [drms_pkg::IRQ_W-1:0] int_mask_q,
	output logic [drms_pkg::MST_W-1:0] mode_status_q,
	output logic fetch_start_q,
	output logic [drms_pkg::ADDR_W-1:0] fetch_addr_q,
	input wire drms_pkg::drms_req_s req,
	input wire logic req_valid,
	output logic req_ready_q,
	output logic done_q,
	output logic err_q,
	// External memory bus.
	input wire logic bus_req_pin,
	output logic bus_grant_q,
	output logic [drms_pkg::ADDR_W-1:0] ext_addr_q,
	output drms_pkg::drms_sel_s sel_q,
	output logic sel_oe_q
);
	logic [4:0] pin_s;
	logic [drms_pkg::MODE_W-1:0] mode_q;
	logic bus_req_s;
	logic flag_s;
	logic [31:0] sysctl_q;
	logic [31:0] ovlay_q;
	logic [31:0] wait_q;
	logic [3:0] comp_cfg_q;
	logic refused_q;
	drms_pkg::drms_boot_e boot_q;
	drms_pkg::drms_acc_e acc_q;
	logic [7:0] awaddr_q;
	logic [7:0] araddr_q;
	logic aw_full_q;
	logic w_full_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic do_write;
	logic accept;
	logic is_ext;
	logic host;
	logic refuse;
	logic [1:0] ovl;
	logic [drms_pkg::WAIT_W-1:0] wait_n;
	logic cnt_zero;
	logic [3:0] act;
	logic [4:0] h_cnt;
	logic [drms_pkg::WAIT_W-1:0] h_wait;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction

	drms_pin_sync #(.W(5), .STRAP_W(drms_pkg::MODE_W)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin({bus_req_pin, shared_flag_pin_i, shared_flag_pin_i, mode_b_pin, mode_a_pin}),
		.pin_sync(pin_s),
		.strap_q(mode_q)
	);
	assign bus_req_s = pin_s[4];
	assign flag_s = pin_s[3];
	assign host = mode_q[drms_pkg::MODE_C];

	// The pin is released through reset so an outside strap driver can win.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shared_flag_pin_oe <= 1'b0;
			shared_flag_pin_o <= 1'b0;
		end else begin
			shared_flag_pin_oe <= sysctl_q[drms_pkg::SYS_FLAG_DIR];
			shared_flag_pin_o <= sysctl_q[drms_pkg::SYS_FLAG_OUT];
		end
	end

	// AXI write path: address and data are held separately, in either order.
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (aw_hs) begin
				aw_full_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (do_write) begin
				aw_full_q <= 1'b0;
			end
			if (w_hs) begin
				w_full_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (do_write) begin
				w_full_q <= 1'b0;
			end
			s_axi_awready <= !(aw_full_q || aw_hs) && !s_axi_bvalid && !do_write;
			s_axi_wready <= !(w_full_q || w_hs) && !s_axi_bvalid && !do_write;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= drms_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (awaddr_q > drms_pkg::OFF_IRQMASK) ? drms_pkg::RESP_SLVERR
				: drms_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sysctl_q <= 32'h0000_0000;
		end else if (do_write && hit(awaddr_q, drms_pkg::OFF_SYSCTL)) begin
			sysctl_q <= merge(sysctl_q, wdata_q, wstrb_q) & 32'h0000_000b;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovlay_q <= 32'h0000_0000;
		end else if (do_write && hit(awaddr_q, drms_pkg::OFF_OVLAY)) begin
			ovlay_q <= merge(ovlay_q, wdata_q, wstrb_q) & 32'h0000_0033;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wait_q <= 32'h0000_0000;
		end else if (do_write && hit(awaddr_q, drms_pkg::OFF_WAIT)) begin
			wait_q <= merge(wait_q, wdata_q, wstrb_q) & 32'h0077_7777;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			comp_cfg_q <= drms_pkg::COMP_CFG_RESET;
		end else if (do_write && hit(awaddr_q, drms_pkg::OFF_CMSCFG) && wstrb_q[0]) begin
			comp_cfg_q <= wdata_q[3:0];
		end
	end

	// Reset leaves every interrupt masked and the mode status clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_status_q <= '0;
			int_mask_q <= '0;
			stack_clear_q <= 1'b1;
		end else begin
			stack_clear_q <= 1'b0;
			if (do_write && hit(awaddr_q, drms_pkg::OFF_MODE_STAT) && wstrb_q[0]) begin
				mode_status_q <= wdata_q[drms_pkg::MST_W-1:0];
			end
			if (do_write && hit(awaddr_q, drms_pkg::OFF_IRQMASK) && wstrb_q[0]) begin
				int_mask_q <= wdata_q[drms_pkg::IRQ_W-1:0];
			end
		end
	end

	// A refusal in the same cycle as the clearing write stays set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			refused_q <= 1'b0;
		end else if (accept && refuse) begin
			refused_q <= 1'b1;
		end else if (do_write && hit(awaddr_q, drms_pkg::OFF_STATUS)
			&& wstrb_q[0] && wdata_q[drms_pkg::ST_REFUSED]) begin
			refused_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= drms_pkg::RESP_OKAY;
			araddr_q <= 8'h00;
		end else begin
			s_axi_arready <= !ar_hs && !s_axi_rvalid;
			if (ar_hs) begin
				araddr_q <= s_axi_araddr;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= drms_pkg::RESP_OKAY;
				unique case (s_axi_araddr[7:2])
					drms_pkg::OFF_SYSCTL[7:2]: s_axi_rdata <= sysctl_q;
					drms_pkg::OFF_OVLAY[7:2]: s_axi_rdata <= ovlay_q;
					drms_pkg::OFF_WAIT[7:2]: s_axi_rdata <= wait_q;
					drms_pkg::OFF_CMSCFG[7:2]: s_axi_rdata <= {28'h0000000, comp_cfg_q};
					drms_pkg::OFF_MODE_STAT[7:2]: s_axi_rdata <= {24'h000000, mode_status_q};
					drms_pkg::OFF_STATUS[7:2]: s_axi_rdata <= {24'h000000, flag_s, refused_q,
						bus_grant_q, boot_q == drms_pkg::BT_RUN,
						boot_q == drms_pkg::BT_BOOT, mode_q};
					drms_pkg::OFF_IRQMASK[7:2]: s_axi_rdata <= {24'h000000, int_mask_q};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= drms_pkg::RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Reset never gates the clock, so leaving it costs no settling time.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boot_q <= drms_pkg::BT_RESET;
			fetch_start_q <= 1'b0;
			fetch_addr_q <= drms_pkg::FETCH_ADDR;
		end else begin
			fetch_start_q <= 1'b0;
			unique case (boot_q)
				drms_pkg::BT_RESET: begin
					if (mode_q[drms_pkg::MODE_B]) begin
						boot_q <= drms_pkg::BT_RUN;
						fetch_start_q <= 1'b1;
					end else if (!bus_req_s) begin
						boot_q <= drms_pkg::BT_BOOT;
					end
				end
				drms_pkg::BT_BOOT: begin
					if (boot_done) begin
						boot_q <= drms_pkg::BT_RUN;
						fetch_start_q <= 1'b1;
						fetch_addr_q <= drms_pkg::FETCH_ADDR;
					end
				end
				drms_pkg::BT_RUN: begin
					boot_q <= drms_pkg::BT_RUN;
				end
			endcase
		end
	end

	// Access decode; program and data overlays share one encoding.
	assign ovl = (req.space == drms_pkg::SP_PM) ? ovlay_q[drms_pkg::OVL_PM_LSB +: 2]
		: ovlay_q[drms_pkg::OVL_DM_LSB +: 2];
	always_comb begin
		is_ext = 1'b0;
		wait_n = '0;
		unique case (req.space)
			drms_pkg::SP_PM, drms_pkg::SP_DM: begin
				is_ext = req.addr[drms_pkg::LOW_W]
					&& (ovl == drms_pkg::OVL_EXT1 || ovl == drms_pkg::OVL_EXT2);
				wait_n = (req.space == drms_pkg::SP_PM) ? wait_q[drms_pkg::WT_P_LSB +: 3]
					: wait_q[drms_pkg::WT_D_LSB +: 3];
			end
			drms_pkg::SP_IO: begin
				is_ext = 1'b1;
				wait_n = wait_q[drms_pkg::WT_IO_LSB
					+ drms_pkg::WT_IO_STEP * req.addr[drms_pkg::IO_REG_LSB +: 2] +: 3];
			end
			drms_pkg::SP_BM: begin
				is_ext = 1'b1;
				wait_n = wait_q[drms_pkg::WT_D_LSB +: 3];
			end
		endcase
	end
	// Host mode has only a 16-bit data path, so outside program accesses are refused.
	assign refuse = host && is_ext && req.space == drms_pkg::SP_PM;
	assign accept = acc_q == drms_pkg::AC_IDLE && req_valid && req_ready_q;
	assign act = {req.space == drms_pkg::SP_IO, req.space == drms_pkg::SP_BM,
		req.space == drms_pkg::SP_DM, req.space == drms_pkg::SP_PM};

	drms_wait_count #(.W(drms_pkg::WAIT_W)) u_wait (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(accept && is_ext && !refuse),
		.load_val(wait_n),
		.zero(cnt_zero)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= drms_pkg::AC_IDLE;
			req_ready_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
			bus_grant_q <= 1'b0;
			sel_oe_q <= 1'b1;
			sel_q <= '1;
			ext_addr_q <= '0;
		end else begin
			done_q <= 1'b0;
			err_q <= 1'b0;
			unique case (acc_q)
				drms_pkg::AC_IDLE: begin
					req_ready_q <= !accept && !bus_req_s && boot_q == drms_pkg::BT_RUN;
					if (accept && (!is_ext || refuse)) begin
						done_q <= 1'b1;
						err_q <= refuse;
					end else if (accept) begin
						acc_q <= drms_pkg::AC_STROBE;
						sel_q.program_memory_select_n <= !act[0];
						sel_q.data_memory_select_n <= !act[1];
						sel_q.byte_memory_select_n <= !(act[2]
							&& !sysctl_q[drms_pkg::SYS_BYTE_DIS]);
						sel_q.io_space_select_n <= !act[3];
						sel_q.composite_select_n <= !(|(act & comp_cfg_q));
						unique case (req.space)
							drms_pkg::SP_IO: ext_addr_q <= {3'h0, req.addr[drms_pkg::IO_W-1:0]};
							drms_pkg::SP_BM: ext_addr_q <= req.addr;
							drms_pkg::SP_PM, drms_pkg::SP_DM: ext_addr_q <= host
								? {13'h0000, req.addr[0]}
								: {ovl == drms_pkg::OVL_EXT2, req.addr[drms_pkg::LOW_W-1:0]};
						endcase
					end else if (bus_req_s && !req_ready_q) begin
						acc_q <= drms_pkg::AC_GRANT;
						bus_grant_q <= 1'b1;
						sel_oe_q <= 1'b0;
					end
				end
				drms_pkg::AC_STROBE: begin
					if (cnt_zero) begin
						acc_q <= drms_pkg::AC_IDLE;
						sel_q <= '1;
						done_q <= 1'b1;
					end
				end
				drms_pkg::AC_GRANT: begin
					if (!bus_req_s) begin
						acc_q <= drms_pkg::AC_IDLE;
						bus_grant_q <= 1'b0;
						sel_oe_q <= 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || accept) begin
			h_cnt <= 5'h00;
			h_wait <= wait_n;
		end else if (acc_q == drms_pkg::AC_STROBE) begin
			h_cnt <= h_cnt + 5'h01;
		end
	end

	int_one_cycle_a: assert property (@(posedge aclk) disable iff (!aresetn)
		accept && !is_ext |=> done_q && !err_q && sel_q.data_memory_select_n)
		else $error("internal access not one cycle");
	strobe_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
		acc_q == drms_pkg::AC_STROBE ##1 acc_q == drms_pkg::AC_IDLE
		|-> done_q && h_cnt == {2'b00, h_wait} + 5'h01)
		else $error("strobe length differs from wait setting");
	comp_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(sel_q.data_memory_select_n) && $past(comp_cfg_q[drms_pkg::COMP_DATA])
		|-> !sel_q.composite_select_n)
		else $error("composite select missed data select");
	byte_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(sel_q.byte_memory_select_n) |-> !$past(sysctl_q[drms_pkg::SYS_BYTE_DIS]))
		else $error("byte select asserted while disabled");
	grant_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
		bus_grant_q |-> !sel_oe_q && sel_q.composite_select_n)
		else $error("selects driven while bus granted");
	reset_clear_a: assert property (@(posedge aclk) !aresetn |=>
		mode_status_q == '0 && int_mask_q == '0 && stack_clear_q)
		else $error("reset did not clear core state");
	comp_reset_a: assert property (@(posedge aclk) !aresetn |=>
		comp_cfg_q == drms_pkg::COMP_CFG_RESET)
		else $error("composite enables wrong after reset");
	host_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
		accept && refuse |=> err_q && done_q && sel_q.program_memory_select_n ##1 refused_q)
		else $error("host mode program access not refused");
	boot_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		boot_q == drms_pkg::BT_RESET && bus_req_s |=> boot_q != drms_pkg::BT_BOOT)
		else $error("boot began with bus request pending");
	first_fetch_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(boot_q == drms_pkg::BT_RUN) |-> fetch_start_q
		&& fetch_addr_q == drms_pkg::FETCH_ADDR)
		else $error("first fetch not from location zero");
	io_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
		accept && req.space == drms_pkg::SP_IO |=> ext_addr_q[13:11] == 3'h0)
		else $error("io upper address bits driven");
	ovl_a13_a: assert property (@(posedge aclk) disable iff (!aresetn)
		accept && !host && is_ext && ovl == drms_pkg::OVL_EXT2
		&& req.space == drms_pkg::SP_PM |=> ext_addr_q[13])
		else $error("overlay two did not raise A13");
endmodule
`default_nettype wire

// ===== test/drms_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
module drms_ext_model (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Strap driver and flag pin.
	input wire logic strap_c,
	input wire logic flag_o,
	input wire logic flag_oe,
	output logic flag_i,
	// Memory selects seen by the external memories.
	input wire logic arm,
	input wire drms_pkg::drms_sel_s sel,
	output logic [7:0] sel_cnt_q,
	output logic [7:0] comp_cnt_q
);
	logic last_q;
	// The released strap line shows the inverse of its last level, so a late sample shows up.
	assign flag_i = flag_oe ? flag_o : (!aresetn ? strap_c : ~last_q);
	always_ff @(posedge aclk) begin
		if (!aresetn) last_q <= strap_c;
	end
	// Counts strobe cycles of one access; cleared while a new request is offered.
	always_ff @(posedge aclk) begin
		if (arm) begin
			sel_cnt_q <= 8'h0;
			comp_cnt_q <= 8'h0;
		end else begin
			if (!(sel.program_memory_select_n & sel.data_memory_select_n
				& sel.byte_memory_select_n & sel.io_space_select_n)) begin
				sel_cnt_q <= sel_cnt_q + 8'h1;
			end
			if (!sel.composite_select_n) begin
				comp_cnt_q <= comp_cnt_q + 8'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== test/dsp_reset_and_memory_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_reset_and_memory_select_tb_top;
	logic aclk, aresetn, awv, wv, brd, arv, rrd, awr, wr_r, bv, arr, rv;
	logic [7:0] awa, ara, scnt, ccnt, imask, mode_stat;
	logic [31:0] wd, rdat;
	logic [1:0] bresp, rresp;
	logic strap_c, mode_b, fo, foe, fi, boot_done, rqv, breq, rdy, done, err, grant, soe, stk, fst;
	logic [13:0] fad, ea;
	drms_pkg::drms_req_s req;
	drms_pkg::drms_sel_s sel;
	int err_count, n_tests, i, k;
	drms_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd), .mode_a_pin(1'h0),
		.mode_b_pin(mode_b), .shared_flag_pin_i(fi), .shared_flag_pin_o(fo),
		.shared_flag_pin_oe(foe), .boot_done(boot_done), .stack_clear_q(stk),
		.int_mask_q(imask), .mode_status_q(mode_stat), .fetch_start_q(fst), .fetch_addr_q(fad),
		.req(req), .req_valid(rqv), .req_ready_q(rdy), .done_q(done), .err_q(err),
		.bus_req_pin(breq), .bus_grant_q(grant), .ext_addr_q(ea), .sel_q(sel), .sel_oe_q(soe));
	drms_ext_model ext (.aclk(aclk), .aresetn(aresetn), .strap_c(strap_c), .flag_o(fo),
		.flag_oe(foe), .flag_i(fi), .arm(rqv), .sel(sel), .sel_cnt_q(scnt), .comp_cnt_q(ccnt));
	initial begin
		aclk = 1'h0;
		forever #12.5 aclk = ~aclk;
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task test_done;
		$display("mismatches %0d comparisons %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// A wait that used up its bound ends the run at once.
	task tmo;
		if (i >= 60) begin
			err_count++;
			test_done();
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		brd <= 1'h1;
		for (i = 0; i < 60; i++) begin
			@(posedge aclk);
			if (awr) awv <= 1'h0;
			if (wr_r) wv <= 1'h0;
			if (bv) break;
		end
		tmo();
		brd <= 1'h0;
		chk("bresp", {30'h0, r}, {30'h0, bresp});
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r);
		ara <= a;
		arv <= 1'h1;
		rrd <= 1'h1;
		for (i = 0; i < 60; i++) begin
			@(posedge aclk);
			if (arr) arv <= 1'h0;
			if (rv) break;
		end
		tmo();
		chk("rdata", e, rdat & m);
		chk("rresp", {30'h0, r}, {30'h0, rresp});
	endtask
	task acc(input logic [1:0] sp, input logic [13:0] a, input logic e, input logic [7:0] ns,
		input logic [7:0] nc, input logic [13:0] m, input logic [13:0] x);
		req <= '{drms_pkg::drms_space_e'(sp), 1'h0, a};
		rqv <= 1'h1;
		for (i = 0; i < 60; i++) begin
			@(posedge aclk);
			if (rdy) break;
		end
		tmo();
		rqv <= 1'h0;
		for (i = 0; i < 60; i++) begin
			@(posedge aclk);
			if (done) break;
		end
		tmo();
		chk("err", {31'h0, e}, {31'h0, err});
		chk("sel_cycles", {24'h0, ns}, {24'h0, scnt});
		chk("comp_cycles", {24'h0, nc}, {24'h0, ccnt});
		chk("ext_addr", {18'h0, x}, {18'h0, ea & m});
	endtask
	// Straps change only while reset is low; boot, when strapped, ends by one pulse.
	task rst(input logic c, input logic b);
		aresetn <= 1'h0;
		strap_c <= c;
		mode_b <= b;
		repeat (5) @(posedge aclk);
		chk("stack_clear", 32'h1, {31'h0, stk});
		aresetn <= 1'h1;
		@(posedge aclk);
		boot_done <= 1'h1;
		@(posedge aclk);
		boot_done <= 1'h0;
		@(posedge aclk);
	endtask
	initial begin
		{aresetn, awv, wv, brd, arv, rrd, strap_c, mode_b, boot_done, rqv, breq} = 11'h0;
		{awa, ara, wd} = 48'h0;
		req = '{drms_pkg::SP_PM, 1'h0, 14'h0};
		err_count = 0;
		n_tests = 0;
		rst(1'h0, 1'h1);
		chk("int_mask", 32'h0, {24'h0, imask});
		chk("mode_status", 32'h0, {24'h0, mode_stat});
		chk("fetch_addr", 32'h0, {18'h0, fad});
		rd(8'h14, 32'h7f, 32'h12, 2'h0);
		rst(1'h0, 1'h0);
		rd(8'h14, 32'h7f, 32'h10, 2'h0);
		rd(8'h0c, 32'hf, 32'hb, 2'h0);
		rd(8'h1c, 32'hffffffff, 32'h0, 2'h2);
		wr(8'h08, 32'h75312, 2'h0);
		rd(8'h08, 32'h77777, 32'h75312, 2'h0);
		wr(8'h04, 32'h12, 2'h0);
		for (k = 0; k < 4; k++) begin
			acc(2'h3, {3'h0, k[1:0], 9'h0a}, 1'h0, 8'(2*k+2), 8'(2*k+2), 14'h7ff, {3'h0, k[1:0], 9'h0a});
		end
		acc(2'h1, 14'h2005, 1'h0, 8'h3, 8'h3, 14'h3fff, 14'h0005);
		acc(2'h0, 14'h2007, 1'h0, 8'h1, 8'h1, 14'h3fff, 14'h2007);
		acc(2'h1, 14'h0100, 1'h0, 8'h0, 8'h0, 14'h0, 14'h0);
		acc(2'h2, 14'h0010, 1'h0, 8'h3, 8'h0, 14'h0, 14'h0);
		wr(8'h00, 32'h8, 2'h0);
		acc(2'h2, 14'h0010, 1'h0, 8'h0, 8'h0, 14'h0, 14'h0);
		breq <= 1'h1;
		for (i = 0; i < 60; i++) begin
			@(posedge aclk);
			if (grant) break;
		end
		tmo();
		@(posedge aclk);
		chk("sel_oe", 32'h0, {31'h0, soe});
		breq <= 1'h0;
		for (i = 0; i < 60; i++) begin
			@(posedge aclk);
			if (!grant) break;
		end
		tmo();
		rst(1'h1, 1'h0);
		rd(8'h14, 32'h7f, 32'h14, 2'h0);
		wr(8'h04, 32'h11, 2'h0);
		acc(2'h0, 14'h2000, 1'h1, 8'h0, 8'h0, 14'h0, 14'h0);
		acc(2'h1, 14'h2003, 1'h0, 8'h1, 8'h1, 14'h3fff, 14'h0001);
		rd(8'h14, 32'h40, 32'h40, 2'h0);
		test_done();
	end
endmodule
`default_nettype wire
